//--- design/dual_wiper_command_store.sv
// Command decoder and wiper storage of a dual 256-tap potentiometer
//
// Function
// - Volatile write loads data into selected wipers at once.
// - Persistent write stores data; wiper position stays.
// - Recall copies stored values into selected wipers.
// - Store copies selected wipers into the persistent store.
// - A 16-bit store holds both wipers across power loss.
// - Store leaves the factory at midscale for both wipers.
// - Protect pin high or open blocks every persistent write.
// - Under protection wipers change only from the store.
// - Protect pin low allows store writes and direct wiper writes.
// - After power-up wipers load from the persistent store.
// - Power-up load finishes within 10 us, then commands accepted.
// - Command byte: zero, transfer, persistent, volatile, select code.
// - Standby whenever not programming, except during the power-up load; leave it when addressed.
`timescale 1ns/10ps
`default_nettype none
`include "dwcs_cfg.svh"
module dual_wiper_command_store (
   // System clock and resets
   input  wire logic                 i_clk,
   input  wire logic                 i_rstn,
   input  wire logic                 i_factory_rstn,
   // Serial link pins
   input  wire logic                 i_scl,
   input  wire logic                 i_sda,
   output logic                      o_sda,
   output logic                      o_sda_oe_n,
   // Straps
   input  wire logic [2:0]           i_address_pin_bits,
   input  wire logic                 i_write_protect_pin,
   // Wiper positions and status
   output dwcs_pkg::wiper_pair_t     o_wiper,
   output logic                      o_ready,
   output logic                      o_standby,
   output logic                      o_protect_active,
   output dwcs_pkg::result_t         o_result
);
   import dwcs_pkg::*;

   localparam int          POWERUP_CYCLES = `CFG_POWERUP_CYCLES;
   localparam logic [9:0]  POWERUP_LAST   = 10'(POWERUP_CYCLES - 1);

   // ======================================================================
   // Declarations
   state_t      state;
   state_t      next_state;
   logic [9:0]  init_count;
   logic [4:0]  sync1;
   logic [4:0]  sync2;
   logic        scl_d;
   logic        sda_d;
   logic        done_d;
   logic        link_idle;
   logic [3:0]  quiet_count;
   logic        frame_rstn;
   frame_t      link_frame;
   logic        link_done;
   logic        link_addressed;
   logic        link_sda_oe_n;
   frame_t      frame;
   decoded_t    dec;
   wiper_pair_t stored;
   wiper_pair_t data_pair;
   logic        store_wr_en;
   wiper_pair_t store_wr_data;
   logic        start_seen;
   logic        stop_seen;
   logic        frame_event;
   logic        scl_s;
   logic        sda_s;
   logic        protect;
   logic        addressed_s;

   // ======================================================================
   // Pin and crossing synchronisers: scl, sda, protect, addressed, done
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync1 <= 5'h1F;
         sync2 <= 5'h1F;
      end else begin
         sync1 <= {i_scl, i_sda, i_write_protect_pin, link_addressed,
                   link_done};
         sync2 <= sync1;
      end
   end

   assign scl_s       = sync2[4];
   assign sda_s       = sync2[3];
   assign protect     = sync2[2];
   assign addressed_s = sync2[1];

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
         done_d   <= 1'b1;
      end else begin
         scl_d    <= scl_s;
         sda_d    <= sda_s;
         done_d   <= sync2[0];
      end
   end

   // The link clock outruns i_clk, so line edges inside a frame cannot be
   // trusted: a start is taken only on an idle bus, and a frame ends once
   // both lines have stood high for a run of samples
   assign start_seen  = link_idle && scl_s && scl_d && sda_d && !sda_s;
   assign stop_seen   = (quiet_count == `CFG_QUIET_LAST);
   assign frame_event = sync2[0] && !done_d;

   // ======================================================================
   // Frame boundary: the link logic is held in reset between frames
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         quiet_count <= 4'h0;
      end else if (!(scl_s && sda_s)) begin
         quiet_count <= 4'h0;
      end else if (!stop_seen) begin
         quiet_count <= quiet_count + 4'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         link_idle <= 1'b1;
      end else if (start_seen) begin
         link_idle <= 1'b0;
      end else if (stop_seen) begin
         link_idle <= 1'b1;
      end
   end

   assign frame_rstn = !link_idle;

   // ======================================================================
   // Link clock domain receiver
   dwcs_link_rx u_link_rx (
      .i_scl              (i_scl),
      .i_frame_rstn       (frame_rstn),
      .i_sda              (i_sda),
      .i_address_pin_bits (i_address_pin_bits),
      .o_frame            (link_frame),
      .o_frame_done       (link_done),
      .o_addressed        (link_addressed),
      .o_sda_oe_n         (link_sda_oe_n)
   );

   assign o_sda_oe_n = link_sda_oe_n;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_sda <= 1'b0;
      end else begin
         o_sda <= 1'b0;
      end
   end

   // ======================================================================
   // Frame capture: the link holds the words stable until the next frame
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         frame <= '0;
      end else if (frame_event) begin
         frame <= link_frame;
      end
   end

   assign dec       = decode_command(frame.cmd);
   assign data_pair = {frame.data, frame.data};

   // ======================================================================
   // Control state machine
   always_comb begin
      next_state = state;
      case (state)
         ST_INIT: begin
            if (init_count == POWERUP_LAST) begin
               next_state = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            if (frame_event) begin
               next_state = ST_EXEC;
            end else if (addressed_s) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (frame_event) begin
               next_state = ST_EXEC;
            end else if (!addressed_s || link_idle) begin
               next_state = ST_STANDBY;
            end
         end
         ST_EXEC: begin
            next_state = ST_STANDBY;
         end
         default: begin
            next_state = ST_INIT;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= ST_INIT;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         init_count <= 10'h000;
      end else if (state == ST_INIT && init_count != POWERUP_LAST) begin
         init_count <= init_count + 10'h001;
      end
   end

   // ======================================================================
   // Wiper registers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_wiper <= {`CFG_MIDSCALE, `CFG_MIDSCALE};
      end else if (state == ST_INIT && init_count == 10'h000) begin
         o_wiper <= stored;
      end else if (state == ST_EXEC && dec.valid) begin
         case (dec.op)
            OP_VOLATILE: begin
               if (!protect) begin
                  o_wiper <= merge_wipers(o_wiper, data_pair,
                                          dec.mask);
               end
            end
            OP_RECALL: begin
               o_wiper <= merge_wipers(o_wiper, stored, dec.mask);
            end
            default: begin
               o_wiper <= o_wiper;
            end
         endcase
      end
   end

   // ======================================================================
   // Persistent store writes
   always_comb begin
      store_wr_en   = 1'b0;
      store_wr_data = data_pair;
      if (state == ST_EXEC && dec.valid && !protect) begin
         if (dec.op == OP_PERSIST) begin
            store_wr_en = 1'b1;
         end else if (dec.op == OP_STORE) begin
            store_wr_en   = 1'b1;
            store_wr_data = o_wiper;
         end
      end
   end

   dwcs_persistent_store u_store (
      .i_clk          (i_clk),
      .i_factory_rstn (i_factory_rstn),
      .i_wr_en        (store_wr_en),
      .i_wr_mask      (dec.mask),
      .i_wr_data      (store_wr_data),
      .o_data         (stored)
   );

   // ======================================================================
   // Status outputs
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_result <= RES_NONE;
      end else if (state == ST_EXEC) begin
         if (!dec.valid) begin
            o_result <= RES_INVALID;
         end else if (protect && dec.op != OP_RECALL) begin
            o_result <= RES_PROTECTED;
         end else begin
            o_result <= RES_DONE;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ready          <= 1'b0;
         o_standby        <= 1'b0;
         o_protect_active <= 1'b1;
      end else begin
         o_ready          <= (next_state != ST_INIT);
         o_standby        <= (next_state == ST_STANDBY);
         o_protect_active <= protect;
      end
   end

endmodule : dual_wiper_command_store
`default_nettype wire

//--- design/dwcs_cfg.svh
// Constants of the dual wiper command store: codes, positions and timing
`ifndef DWCS_CFG_SVH
`define DWCS_CFG_SVH

// ==========================================================================
// Address byte
`define CFG_ADDR_FIXED      4'h5
`define CFG_WRITE_SELECT    1'h0

// ==========================================================================
// Command byte fields and codes
`define CFG_OP_VOLATILE     3'h1
`define CFG_OP_PERSIST      3'h2
`define CFG_OP_RECALL       3'h6
`define CFG_OP_STORE        3'h5
`define CFG_SEL_A           4'h1
`define CFG_SEL_B           4'h2
`define CFG_SEL_BOTH        4'h3

// ==========================================================================
// Factory and reset values
`define CFG_MIDSCALE        8'h80

// ==========================================================================
// Bus clock cycle numbers of the last bit of each byte and of each ACK
`define CFG_CYC_ADDR_END    5'h08
`define CFG_CYC_ADDR_ACK    5'h09
`define CFG_CYC_CMD_END     5'h11
`define CFG_CYC_CMD_ACK     5'h12
`define CFG_CYC_DATA_END    5'h1A
`define CFG_CYC_DATA_ACK    5'h1B

// ==========================================================================
// Timing
`define CFG_CLK_HZ          50000000
`define CFG_POWERUP_NS      10000
// Samples of a bus with both lines high that end a frame
`define CFG_QUIET_LAST      4'hF
`define CFG_POWERUP_CYCLES  ((`CFG_POWERUP_NS * (`CFG_CLK_HZ / 1000000)) / 1000)

`endif

//--- design/dwcs_pkg.sv
// Types and helper functions of the dual wiper command store
package dwcs_pkg;
`include "dwcs_cfg.svh"

   // =======================================================================
   // Carriers
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] cmd;
      logic [7:0] data;
   } frame_t;

   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
   } wiper_pair_t;

   typedef enum logic [1:0] {
      ST_INIT    = 2'h0,
      ST_STANDBY = 2'h1,
      ST_ACTIVE  = 2'h3,
      ST_EXEC    = 2'h2
   } state_t;

   typedef enum logic [2:0] {
      OP_NONE     = 3'h0,
      OP_VOLATILE = `CFG_OP_VOLATILE,
      OP_PERSIST  = `CFG_OP_PERSIST,
      OP_RECALL   = `CFG_OP_RECALL,
      OP_STORE    = `CFG_OP_STORE
   } op_t;

   typedef enum logic [1:0] {
      RES_NONE      = 2'h0,
      RES_DONE      = 2'h1,
      RES_PROTECTED = 2'h2,
      RES_INVALID   = 2'h3
   } result_t;

   typedef struct packed {
      logic       valid;
      op_t        op;
      logic [1:0] mask;
   } decoded_t;

   // =======================================================================
   // Command byte decode: zero, transfer, persistent, volatile, select
   function automatic decoded_t decode_command(input logic [7:0] cmd);
      decoded_t d;
      d.valid = 1'b0;
      d.op    = OP_NONE;
      d.mask  = 2'h0;
      case (cmd[3:0])
         `CFG_SEL_A:    d.mask = 2'h1;
         `CFG_SEL_B:    d.mask = 2'h2;
         `CFG_SEL_BOTH: d.mask = 2'h3;
         default:       d.mask = 2'h0;
      endcase
      case (cmd[6:4])
         `CFG_OP_VOLATILE: d.op = OP_VOLATILE;
         `CFG_OP_PERSIST:  d.op = OP_PERSIST;
         `CFG_OP_RECALL:   d.op = OP_RECALL;
         `CFG_OP_STORE:    d.op = OP_STORE;
         default:          d.op = OP_NONE;
      endcase
      d.valid = !cmd[7] && (d.mask != 2'h0) && (d.op != OP_NONE);
      return d;
   endfunction : decode_command

   // Replace the wipers selected by mask, keep the others
   function automatic wiper_pair_t merge_wipers(input wiper_pair_t old_v,
                                                input wiper_pair_t new_v,
                                                input logic [1:0]  mask);
      wiper_pair_t r;
      r.a = mask[0] ? new_v.a : old_v.a;
      r.b = mask[1] ? new_v.b : old_v.b;
      return r;
   endfunction : merge_wipers

endpackage : dwcs_pkg

//--- design/dwcs_link_rx.sv
// Bus clock domain receiver: bit counter, byte capture and acknowledge
`timescale 1ns/10ps
`default_nettype none
`include "dwcs_cfg.svh"
module dwcs_link_rx (
   // Link clock and frame reset (low between frames)
   input  wire logic             i_scl,
   input  wire logic             i_frame_rstn,
   // Pins
   input  wire logic             i_sda,
   input  wire logic [2:0]       i_address_pin_bits,
   // Received frame, held until the next frame starts
   output dwcs_pkg::frame_t      o_frame,
   output logic                  o_frame_done,
   output logic                  o_addressed,
   // Open-drain acknowledge, enable low while driving low
   output logic                  o_sda_oe_n
);
   import dwcs_pkg::*;

   logic [4:0] cycle;
   logic [6:0] shift;
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [4:0] next_cycle;
   logic [7:0] next_byte;
   logic       addr_match;

   assign next_cycle = (cycle == `CFG_CYC_DATA_ACK) ? cycle : cycle + 5'h01;
   assign next_byte  = {shift, i_sda};
   assign addr_match = (next_byte[7:1] == {`CFG_ADDR_FIXED, pin_s2}) &&
                       (next_byte[0] == `CFG_WRITE_SELECT);

   // ======================================================================
   // Address strap synchroniser
   always_ff @(posedge i_scl or negedge i_frame_rstn) begin
      if (!i_frame_rstn) begin
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
      end else begin
         pin_s1 <= i_address_pin_bits;
         pin_s2 <= pin_s1;
      end
   end

   // ======================================================================
   // Bit counter numbered as bus clock cycles, first address bit is 1
   always_ff @(posedge i_scl or negedge i_frame_rstn) begin
      if (!i_frame_rstn) begin
         cycle <= 5'h00;
         shift <= 7'h00;
      end else begin
         cycle <= next_cycle;
         shift <= next_byte[6:0];
      end
   end

   // ======================================================================
   // Byte capture; frame handed over after the last data bit
   always_ff @(posedge i_scl or negedge i_frame_rstn) begin
      if (!i_frame_rstn) begin
         o_addressed <= 1'b0;
      end else if (next_cycle == `CFG_CYC_ADDR_END) begin
         o_addressed <= addr_match;
      end
   end

   always_ff @(posedge i_scl) begin
      if (next_cycle == `CFG_CYC_ADDR_END) begin
         o_frame.addr <= next_byte;
      end
      if (next_cycle == `CFG_CYC_CMD_END && o_addressed) begin
         o_frame.cmd <= next_byte;
      end
      if (next_cycle == `CFG_CYC_DATA_END && o_addressed) begin
         o_frame.data <= next_byte;
      end
   end

   // Frame complete flag, cleared by the frame reset between frames
   always_ff @(posedge i_scl or negedge i_frame_rstn) begin
      if (!i_frame_rstn) begin
         o_frame_done <= 1'b0;
      end else if (next_cycle == `CFG_CYC_DATA_END && o_addressed) begin
         o_frame_done <= 1'b1;
      end
   end

   // ======================================================================
   // Acknowledge each byte of an addressed frame, data byte included
   always_ff @(negedge i_scl or negedge i_frame_rstn) begin
      if (!i_frame_rstn) begin
         o_sda_oe_n <= 1'b1;
      end else if (cycle == `CFG_CYC_ADDR_END ||
                   cycle == `CFG_CYC_CMD_END ||
                   cycle == `CFG_CYC_DATA_END) begin
         o_sda_oe_n <= !o_addressed;
      end else begin
         o_sda_oe_n <= 1'b1;
      end
   end

endmodule : dwcs_link_rx
`default_nettype wire

//--- design/dwcs_persistent_store.sv
// Persistent 16-bit store holding both wiper values
`timescale 1ns/10ps
`default_nettype none
`include "dwcs_cfg.svh"
module dwcs_persistent_store (
   // Clock and factory initialisation
   input  wire logic                i_clk,
   input  wire logic                i_factory_rstn,
   // Write port
   input  wire logic                i_wr_en,
   input  wire logic [1:0]          i_wr_mask,
   input  wire dwcs_pkg::wiper_pair_t i_wr_data,
   // Stored value
   output dwcs_pkg::wiper_pair_t    o_data
);
   import dwcs_pkg::*;

   // ======================================================================
   // Only the factory reset sets it to midscale; power-on reset leaves it
   always_ff @(posedge i_clk or negedge i_factory_rstn) begin
      if (!i_factory_rstn) begin
         o_data <= {`CFG_MIDSCALE, `CFG_MIDSCALE};
      end else if (i_wr_en) begin
         o_data <= merge_wipers(o_data, i_wr_data, i_wr_mask);
      end
   end

endmodule : dwcs_persistent_store
`default_nettype wire

//--- tb/dwcs_bus_master.sv
// Serial bus master model that sends write frames to the device
`timescale 1ns/10ps
`default_nettype none
module dwcs_bus_master (
   // Bus pins, master side; sda high means released
   output logic        o_scl,
   output logic        o_sda,
   input  wire logic   i_sda
);
   import dwcs_pkg::*;

   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   // ========================================================================
   // One frame: start, n bytes each with acknowledge slot, stop
   // Clock stands high between frames, 12 ns period inside them
   task automatic send(input dwcs_pkg::frame_t f, input int n,
                       output logic [2:0] acks);
      logic [23:0] bits;
      int          i;
      int          j;
      bits  = f;
      acks  = 3'h0;
      o_sda = 1'b0;
      #1000;
      for (i = 0; i < n; i++) begin
         for (j = 0; j < 8; j++) begin
            o_scl = 1'b0;
            #3 o_sda = bits[23 - 8 * i - j];
            #3 o_scl = 1'b1;
            #6;
         end
         o_scl = 1'b0;
         #3 o_sda = 1'b1;
         #3 o_scl = 1'b1;
         #3 acks[2 - i] = !i_sda;
         #3;
      end
      o_scl = 1'b0;
      #3 o_sda = 1'b0;
      #3 o_scl = 1'b1;
      #3 o_sda = 1'b1;
      #1000;
   endtask : send
endmodule : dwcs_bus_master
`default_nettype wire

//--- tb/dual_wiper_command_store_assertions.sv
// Port checker of the dual wiper command store
`timescale 1ns/10ps
`default_nettype none
module dwcs_port_checker (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rstn,
   // Pins
   input  wire logic                  i_write_protect_pin,
   input  wire logic                  o_sda,
   input  wire logic                  o_sda_oe_n,
   // Status
   input  wire dwcs_pkg::wiper_pair_t o_wiper,
   input  wire logic                  o_ready,
   input  wire logic                  o_standby,
   input  wire logic                  o_protect_active,
   input  wire dwcs_pkg::result_t     o_result
);
   import dwcs_pkg::*;

   // ========================================================================
   // Cycles since reset release, saturating
   logic [9:0] up_cycles;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) up_cycles <= 10'h000;
      else if (up_cycles != 10'h3FF) up_cycles <= up_cycles + 10'h001;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   // ========================================================================
   // Assertions
   a_ready_holds: assert property (o_ready |=> o_ready)
      else $error("ready dropped after power-up");
   a_ready_time: assert property (up_cycles >= 10'h1F9 |-> o_ready)
      else $error("power-up load took longer than 10 us");
   a_protect_rise: assert property
      ($rose(i_write_protect_pin) |-> ##[1:4] o_protect_active)
      else $error("protection not raised after pin went high");
   a_protect_fall: assert property
      ($fell(i_write_protect_pin) |-> ##[1:4] !o_protect_active)
      else $error("protection not lifted after pin went low");
   a_standby_return: assert property ($changed(o_result) |-> o_standby)
      else $error("standby not entered after a command");
   a_sda_drive: assert property (!o_sda_oe_n |-> !o_sda)
      else $error("acknowledge does not pull the line low");
   a_wiper_cause: assert property
      ($changed(o_wiper) && $past(o_ready) |-> ##[0:2] o_result == RES_DONE)
      else $error("wiper moved without a completed command");
   a_protect_result: assert property
      (o_result == RES_PROTECTED && $past(o_result) != RES_PROTECTED
       |-> o_protect_active)
      else $error("protected result without protection");

   c_done: cover property (o_result == RES_DONE);
   c_protected: cover property (o_result == RES_PROTECTED);
   c_invalid: cover property (o_result == RES_INVALID);
endmodule : dwcs_port_checker

bind dual_wiper_command_store dwcs_port_checker chk_u (
   .i_clk               (i_clk),
   .i_rstn              (i_rstn),
   .i_write_protect_pin (i_write_protect_pin),
   .o_sda               (o_sda),
   .o_sda_oe_n          (o_sda_oe_n),
   .o_wiper             (o_wiper),
   .o_ready             (o_ready),
   .o_standby           (o_standby),
   .o_protect_active    (o_protect_active),
   .o_result            (o_result)
);
`default_nettype wire

//--- tb/dual_wiper_command_store_tb_top.sv
// Testbench of the dual wiper command store
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin \
   checked++; \
   if ((got) !== (ex)) begin \
      err_count++; \
      $display("mismatch %s expected %h seen %h", nm, ex, got); \
   end \
end
module dual_wiper_command_store_tb_top;
   import dwcs_pkg::*;

   typedef struct packed {
      logic        wp;
      logic [7:0]  cmd;
      logic [7:0]  data;
      logic [15:0] wiper;
      result_t     res;
   } row_t;

   logic        clk;
   logic        rstn;
   logic        factory_rstn;
   logic        m_scl;
   logic        m_sda;
   wire logic   sda_wire;
   logic [2:0]  pins;
   logic        wp;
   logic        sda_out;
   logic        sda_oe_n;
   wiper_pair_t o_wiper;
   logic        o_ready;
   logic        o_standby;
   logic        o_protect_active;
   result_t     o_result;
   logic [2:0]  acks;
   int          err_count = 0;
   int          checked = 0;
   int          i;

   // Open-drain data line with pull-up
   assign sda_wire = m_sda & (sda_oe_n | sda_out);

   // Each row follows from the state the rows before it left
   row_t rows [16] = '{
      '{1'h0, 8'h11, 8'h3C, 16'h3C80, RES_DONE},
      '{1'h0, 8'h12, 8'h5A, 16'h3C5A, RES_DONE},
      '{1'h0, 8'h21, 8'h11, 16'h3C5A, RES_DONE},
      '{1'h0, 8'h61, 8'hFF, 16'h115A, RES_DONE},
      '{1'h0, 8'h13, 8'h77, 16'h7777, RES_DONE},
      '{1'h0, 8'h52, 8'h00, 16'h7777, RES_DONE},
      '{1'h0, 8'h63, 8'h00, 16'h1177, RES_DONE},
      '{1'h0, 8'h23, 8'h99, 16'h1177, RES_DONE},
      '{1'h1, 8'h11, 8'h01, 16'h1177, RES_PROTECTED},
      '{1'h1, 8'h53, 8'h00, 16'h1177, RES_PROTECTED},
      '{1'h1, 8'h21, 8'h44, 16'h1177, RES_PROTECTED},
      '{1'h1, 8'h63, 8'h00, 16'h9999, RES_DONE},
      '{1'h0, 8'h14, 8'h01, 16'h9999, RES_INVALID},
      '{1'h0, 8'h71, 8'h01, 16'h9999, RES_INVALID},
      '{1'h0, 8'h91, 8'h01, 16'h9999, RES_INVALID},
      '{1'h0, 8'h12, 8'h22, 16'h9922, RES_DONE}
   };

   dual_wiper_command_store dut_u (
      .i_clk               (clk),
      .i_rstn              (rstn),
      .i_factory_rstn      (factory_rstn),
      .i_scl               (m_scl),
      .i_sda               (sda_wire),
      .o_sda               (sda_out),
      .o_sda_oe_n          (sda_oe_n),
      .i_address_pin_bits  (pins),
      .i_write_protect_pin (wp),
      .o_wiper             (o_wiper),
      .o_ready             (o_ready),
      .o_standby           (o_standby),
      .o_protect_active    (o_protect_active),
      .o_result            (o_result)
   );

   dwcs_bus_master master_u (
      .o_scl (m_scl),
      .o_sda (m_sda),
      .i_sda (sda_wire)
   );

   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task automatic run(input logic [7:0] a, input logic [7:0] c,
                      input logic [7:0] d, input int n);
      @(posedge clk);
      #1;
      master_u.send({a, c, d}, n, acks);
   endtask : run

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      #200000;
      err_count++;
      wrap_up();
   end

   // ========================================================================
   // Main sequence
   initial begin
      rstn = 1'b0;
      factory_rstn = 1'b0;
      pins = 3'h0;
      wp = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      factory_rstn = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK("wiper", 16'h8080, o_wiper)
      `CHK("ready", 1'b0, o_ready)
      repeat (503) @(posedge clk);
      #1;
      `CHK("ready", 1'b1, o_ready)
      `CHK("standby", 1'b1, o_standby)
      $display("power-up test done");
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         #1;
         wp = rows[i].wp;
         repeat (4) @(posedge clk);
         run(8'h50, rows[i].cmd, rows[i].data, 3);
         `CHK("ack", 3'h7, acks)
         `CHK("wiper", rows[i].wiper, o_wiper)
         `CHK("result", rows[i].res, o_result)
         `CHK("protect", rows[i].wp, o_protect_active)
         `CHK("standby", 1'b1, o_standby)
         $display("row %0d done", i);
      end
      // Refused addresses and a frame without its data byte
      run(8'h60, 8'h11, 8'h01, 3);
      `CHK("ack", 3'h0, acks)
      run(8'h51, 8'h11, 8'h01, 3);
      `CHK("ack", 3'h0, acks)
      run(8'h50, 8'h11, 8'h01, 2);
      `CHK("ack", 3'h6, acks)
      `CHK("wiper", 16'h9922, o_wiper)
      $display("refusal test done");
      // Strapped address
      @(posedge clk);
      #1;
      pins = 3'h5;
      run(8'h5A, 8'h13, 8'h5A, 3);
      `CHK("ack", 3'h7, acks)
      `CHK("wiper", 16'h5A5A, o_wiper)
      run(8'h50, 8'h11, 8'h01, 3);
      `CHK("ack", 3'h0, acks)
      $display("strap test done");
      // Power cycle: wipers reload from the persistent store
      @(posedge clk);
      #1;
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK("wiper", 16'h9999, o_wiper)
      `CHK("ready", 1'b0, o_ready)
      `CHK("result", RES_NONE, o_result)
      $display("power cycle test done");
      wrap_up();
   end
endmodule : dual_wiper_command_store_tb_top
`default_nettype wire
